/* hw/aoc_pkg.sv */
// Shared constants for the converter control block and its host controller.
// Assumes a single 10 MHz clock on both ends.
package aoc_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int ACQ_NS = 250;
    localparam int CONV_NS = 1000;
    localparam int ACQ_CYCLES = (ACQ_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int CONV_CYCLES = (CONV_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int RES_W = 16;
    localparam int BITS_W = 5;
    localparam logic [4:0] BITS_LAST = 5'h0010;
    localparam logic [5:0] SCLK_HALF = 6'h0004;
    localparam logic [5:0] HOST_HALF = 6'h0010;
    localparam logic [3:0] ERR_PULSE = 4'h0008;
    localparam logic [3:0] START_LOW = 4'h0004;
    localparam logic [3:0] PAR_WAIT = 4'h000a;
    // Pin positions inside the shared data bus.
    localparam int BIT_SDO = 8;
    localparam int BIT_SCLK = 9;
    localparam int BIT_SYNC = 10;
    localparam int BIT_ERR = 11;
    localparam logic [15:0] SER_OE_MASK = 16'hfd00;
    localparam logic [15:0] SCLK_OE_MASK = 16'h0200;
    // Device pin inputs, in the order they are synchronised.
    localparam int IN_CS = 0;
    localparam int IN_RD = 1;
    localparam int IN_CNV = 2;
    localparam int IN_RST = 3;
    localparam int IN_PD = 4;
    localparam int IN_SER = 5;
    localparam int IN_EXT = 6;
    localparam int IN_INV = 7;
    localparam int IN_SCLK = 8;
    localparam int IN_REFD = 9;
    localparam int IN_BUFD = 10;
    localparam int NIN = 11;
    localparam logic [10:0] PIN_IDLE = 11'h0007;
    // Host register map and control fields.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam int CTL_GO = 0;
    localparam int CTL_SER = 1;
    localparam int CTL_EXT = 2;
    localparam int CTL_INV = 3;
    localparam int CTL_PD = 4;
    localparam int CTL_RST = 5;
    localparam int CTL_REFD = 6;
    localparam int CTL_BUFD = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_ERR = 2;
    localparam int ST_ENG = 3;
endpackage

/* hw/aoc_if.sv */
// Pin-level link between the converter control block and its host.
// Resolves the shared data bus and the two-way serial clock from the enables.
`timescale 1ns/1ps
`default_nettype none
interface aoc_if;
    logic cs_n;
    logic rd_n;
    logic convert_start_n;
    logic adc_reset;
    logic power_down_request;
    logic serial_parallel_select;
    logic clock_source_select;
    logic frame_sync_invert;
    logic internal_ref_disable;
    logic ref_buffer_disable;
    logic host_sclk;
    logic host_sclk_oe;
    logic [15:0] data;
    logic [15:0] data_oe;
    logic busy;
    wire [15:0] pins;

    // Undriven pins read low; the host clock only lands on the clock pin.
    assign pins = (data & data_oe) | ((host_sclk_oe & host_sclk) ? 16'h0200 : 16'h0000);

    modport dev (
        input cs_n, rd_n, convert_start_n, adc_reset, power_down_request,
        input serial_parallel_select, clock_source_select, frame_sync_invert,
        input internal_ref_disable, ref_buffer_disable, pins,
        output data, data_oe, busy
    );
    modport host (
        output cs_n, rd_n, convert_start_n, adc_reset, power_down_request,
        output serial_parallel_select, clock_source_select, frame_sync_invert,
        output internal_ref_disable, ref_buffer_disable, host_sclk, host_sclk_oe,
        input pins, busy
    );
endinterface
`default_nettype wire

/* hw/aoc_device.sv */
// Conversion control and output multiplexing of the sampling converter.
// Assumes all pin inputs are asynchronous to clk_i; sample_i stands in for the analog front end.
`timescale 1ns/1ps
`default_nettype none
module aoc_device #(
    parameter int ACQ_CYC = aoc_pkg::ACQ_CYCLES,
    parameter int CONV_CYC = aoc_pkg::CONV_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [aoc_pkg::RES_W-1:0] sample_i,
    output logic ref_on_o,
    output logic ref_buf_on_o,
    output logic low_power_o,
    aoc_if.dev pin
);
    import aoc_pkg::*;

    if (ACQ_CYC < 1 || ACQ_CYC > 255 || CONV_CYC < 1 || CONV_CYC > 255) begin : g_chk
        $error("aoc_device: cycle counts must lie in 1..255");
    end

    typedef enum logic [1:0] {AOC_ACQ, AOC_ARM, AOC_CONV} aoc_dev_state_t;

    typedef struct packed {
        logic [NIN-1:0] s1;
        logic [NIN-1:0] s2;
        logic [NIN-1:0] s3;
        logic [NIN-1:0] lvl;
        aoc_dev_state_t st;
        logic [7:0] cnt;
        logic [RES_W-1:0] samp;
        logic [RES_W-1:0] res;
        logic [RES_W-1:0] sh;
        logic [BITS_W-1:0] bitn;
        logic fresh;
        logic int_on;
        logic ext_on;
        logic [5:0] div;
        logic sclk_int;
        logic [3:0] err_cnt;
        logic busy;
        logic [15:0] data;
        logic [15:0] data_oe;
        logic ref_on;
        logic buf_on;
        logic low_pwr;
    } aoc_dev_t;

    localparam aoc_dev_t DEV_RST = '{
        s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE, lvl: PIN_IDLE,
        st: AOC_ACQ, default: '0
    };

    aoc_dev_t r;
    aoc_dev_t n;
    logic [NIN-1:0] raw;
    logic en;
    logic ser;
    logic ext;
    logic start;
    logic sck_rise;
    logic sck_fall;
    logic sync_act;

    assign raw = {pin.ref_buffer_disable, pin.internal_ref_disable, pin.pins[BIT_SCLK],
        pin.frame_sync_invert, pin.clock_source_select, pin.serial_parallel_select,
        pin.power_down_request, pin.adc_reset, pin.convert_start_n, pin.rd_n, pin.cs_n};

    always_comb begin
        n = r;
        n.s1 = raw;
        n.s2 = r.s1;
        n.s3 = r.s2;
        // A level moves only once the second and third stages agree.
        n.lvl = (r.s2 & r.s3) | (r.lvl & (r.s2 ^ r.s3));
        ser = r.lvl[IN_SER];
        ext = r.lvl[IN_EXT];
        en = !r.lvl[IN_CS] && !r.lvl[IN_RD];
        // Edges of the outside clock count only while selected.
        sck_rise = n.lvl[IN_SCLK] && !r.lvl[IN_SCLK] && !r.lvl[IN_CS];
        sck_fall = !n.lvl[IN_SCLK] && r.lvl[IN_SCLK] && !r.lvl[IN_CS];
        start = 1'b0;

        case (r.st)
            AOC_ACQ: begin
                if (r.cnt < 8'(ACQ_CYC - 1)) begin
                    n.cnt = r.cnt + 8'h01;
                end else if (!r.lvl[IN_PD]) begin
                    if (!r.lvl[IN_CNV]) begin
                        start = 1'b1;
                    end else begin
                        n.st = AOC_ARM;
                    end
                end
            end
            AOC_ARM: begin
                if (!r.lvl[IN_PD] && !n.lvl[IN_CNV] && r.lvl[IN_CNV]) begin
                    start = 1'b1;
                end
            end
            AOC_CONV: begin
                n.cnt = r.cnt + 8'h01;
                if (r.cnt == 8'(CONV_CYC - 1)) begin
                    n.st = AOC_ACQ;
                    n.cnt = 8'h00;
                    n.busy = 1'b0;
                    n.res = r.samp;
                    n.fresh = 1'b1;
                    if (r.ext_on) begin
                        // A read still in flight loses its word to the new result.
                        n.ext_on = 1'b0;
                        n.err_cnt = ERR_PULSE;
                    end
                end
            end
            default: begin
                n.st = AOC_ACQ;
            end
        endcase

        if (start) begin
            n.st = AOC_CONV;
            n.cnt = 8'h00;
            n.samp = sample_i;
            n.busy = 1'b1;
        end

        if (r.err_cnt != 4'h0) begin
            n.err_cnt = r.err_cnt - 4'h1;
        end

        // Slave serial read: first rising edge presents the MSB, later ones shift.
        if (ser && ext && r.st != AOC_CONV) begin
            if (sck_rise) begin
                if (!r.ext_on) begin
                    n.ext_on = 1'b1;
                    n.sh = r.res;
                    n.bitn = 5'h01;
                    n.fresh = 1'b0;
                end else begin
                    n.sh = {r.sh[RES_W-2:0], 1'b0};
                    n.bitn = r.bitn + 5'h01;
                end
            end else if (sck_fall && r.ext_on && r.bitn == BITS_LAST) begin
                n.ext_on = 1'b0;
            end
        end

        // Master serial read starts once a fresh result and an enabled bus meet.
        if (ser && !ext && !r.int_on && r.fresh && en && r.st != AOC_CONV) begin
            n.int_on = 1'b1;
            n.fresh = 1'b0;
            n.sh = r.res;
            n.bitn = 5'h00;
            n.div = 6'h00;
            n.sclk_int = 1'b0;
        end else if (r.int_on) begin
            n.div = r.div + 6'h01;
            if (r.div == SCLK_HALF - 6'h01) begin
                n.div = 6'h00;
                n.sclk_int = !r.sclk_int;
                if (r.sclk_int) begin
                    n.sh = {r.sh[RES_W-2:0], 1'b0};
                    n.bitn = r.bitn + 5'h01;
                    if (r.bitn == BITS_LAST - 5'h01) begin
                        n.int_on = 1'b0;
                    end
                end
            end
        end

        sync_act = n.int_on || n.ext_on;
        if (!ser) begin
            n.data = n.res;
            n.data_oe = en ? 16'hffff : 16'h0000;
        end else begin
            n.data = 16'h0000;
            n.data[15:12] = n.res[15:12];
            n.data[BIT_ERR] = ext && (n.err_cnt != 4'h0);
            n.data[BIT_SYNC] = sync_act ^ r.lvl[IN_INV];
            n.data[BIT_SCLK] = n.sclk_int;
            n.data[BIT_SDO] = n.sh[RES_W-1];
            // The clock pin is driven only when the device makes the clock.
            n.data_oe = en ? (SER_OE_MASK | (ext ? 16'h0000 : SCLK_OE_MASK)) : 16'h0000;
        end
        n.ref_on = !r.lvl[IN_REFD];
        n.buf_on = !r.lvl[IN_BUFD];
        n.low_pwr = r.lvl[IN_PD] && n.st != AOC_CONV;

        // The reset pin clears everything except the pin synchronisers.
        if (r.lvl[IN_RST]) begin
            n = '{s1: n.s1, s2: n.s2, s3: n.s3, lvl: n.lvl, st: AOC_ACQ, default: '0};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= DEV_RST;
        end else begin
            r <= n;
        end
    end

    assign pin.data = r.data;
    assign pin.data_oe = r.data_oe;
    assign pin.busy = r.busy;
    assign ref_on_o = r.ref_on;
    assign ref_buf_on_o = r.buf_on;
    assign low_power_o = r.low_pwr;
endmodule
`default_nettype wire

/* hw/aoc_host.sv */
// Host controller that starts conversions and reads results from the converter.
// Software reaches it over a classic Wishbone slave; device pins are asynchronous.
//
// The Wishbone register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module aoc_host (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    aoc_if.host pin
);
    import aoc_pkg::*;

    typedef enum logic [2:0] {AOC_IDLE, AOC_START, AOC_WAITB, AOC_READ, AOC_SHIFT}
        aoc_host_state_t;

    typedef struct packed {
        logic [16:0] s1;
        logic [16:0] s2;
        logic [16:0] s3;
        logic [16:0] lvl;
        aoc_host_state_t st;
        logic [7:0] ctrl;
        logic done;
        logic err;
        logic [RES_W-1:0] data;
        logic [RES_W-1:0] sh;
        logic [BITS_W-1:0] bitn;
        logic [5:0] div;
        logic [3:0] cnt;
        logic cs_n;
        logic rd_n;
        logic cnv_n;
        logic sclk;
        logic sclk_oe;
        logic ack;
        logic [31:0] rdat;
    } aoc_host_s_t;

    localparam aoc_host_s_t HOST_RST = '{st: AOC_IDLE, cs_n: 1'b1, rd_n: 1'b1,
        cnv_n: 1'b1, default: '0};

    aoc_host_s_t r;
    aoc_host_s_t n;
    logic req;
    logic busy_fall;
    logic sck_rise;

    always_comb begin
        n = r;
        n.s1 = {pin.busy, pin.pins};
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.lvl = (r.s2 & r.s3) | (r.lvl & (r.s2 ^ r.s3));
        busy_fall = r.lvl[16] && !n.lvl[16];
        sck_rise = n.lvl[BIT_SCLK] && !r.lvl[BIT_SCLK];
        n.ctrl[CTL_GO] = 1'b0;

        req = wb_cyc_i && wb_stb_i && !r.ack;
        n.ack = req;
        if (req) begin
            n.rdat = 32'h0000_0000;
            case (wb_adr_i)
                REG_CTRL: begin
                    n.rdat[7:0] = r.ctrl;
                    if (wb_we_i && wb_sel_i[0]) begin
                        n.ctrl = wb_dat_i[7:0];
                    end
                end
                REG_STAT: begin
                    n.rdat[ST_BUSY] = r.lvl[16];
                    n.rdat[ST_DONE] = r.done;
                    n.rdat[ST_ERR] = r.err;
                    n.rdat[ST_ENG] = r.st != AOC_IDLE;
                    if (wb_we_i && wb_sel_i[0] && wb_dat_i[ST_ERR]) begin
                        n.err = 1'b0;
                    end
                end
                REG_DATA: begin
                    n.rdat[RES_W-1:0] = r.data;
                    if (!wb_we_i) begin
                        n.done = 1'b0;
                    end
                end
                default: begin
                    n.rdat = 32'h0000_0000;
                end
            endcase
        end

        // Hardware sets win over a software clear in the same cycle.
        if (r.ctrl[CTL_SER] && r.ctrl[CTL_EXT] && r.lvl[BIT_ERR]) begin
            n.err = 1'b1;
        end

        case (r.st)
            AOC_IDLE: begin
                if (r.ctrl[CTL_GO]) begin
                    n.st = AOC_START;
                    n.cnv_n = 1'b0;
                    n.cnt = START_LOW;
                end
            end
            AOC_START: begin
                n.cnt = r.cnt - 4'h1;
                if (r.cnt == 4'h1) begin
                    n.cnv_n = 1'b1;
                    n.st = AOC_WAITB;
                end
            end
            AOC_WAITB: begin
                if (busy_fall) begin
                    n.st = AOC_READ;
                    n.cs_n = 1'b0;
                    n.rd_n = 1'b0;
                    n.cnt = PAR_WAIT;
                    n.bitn = 5'h00;
                    n.div = 6'h00;
                end
            end
            AOC_READ: begin
                n.cnt = r.cnt - 4'h1;
                if (r.cnt == 4'h1) begin
                    if (!r.ctrl[CTL_SER]) begin
                        n.data = r.lvl[15:0];
                        n.done = 1'b1;
                        n.cs_n = 1'b1;
                        n.rd_n = 1'b1;
                        n.st = AOC_IDLE;
                    end else begin
                        n.st = AOC_SHIFT;
                        n.sclk_oe = r.ctrl[CTL_EXT];
                    end
                end
            end
            AOC_SHIFT: begin
                if (r.ctrl[CTL_EXT]) begin
                    n.div = r.div + 6'h01;
                    if (r.div == HOST_HALF - 6'h01) begin
                        n.div = 6'h00;
                        n.sclk = !r.sclk;
                        if (r.sclk) begin
                            n.sh = {r.sh[RES_W-2:0], r.lvl[BIT_SDO]};
                            n.bitn = r.bitn + 5'h01;
                        end
                    end
                end else if (sck_rise) begin
                    n.sh = {r.sh[RES_W-2:0], r.lvl[BIT_SDO]};
                    n.bitn = r.bitn + 5'h01;
                end
                if (r.bitn == BITS_LAST) begin
                    n.data = r.sh;
                    n.done = 1'b1;
                    n.cs_n = 1'b1;
                    n.rd_n = 1'b1;
                    n.sclk = 1'b0;
                    n.sclk_oe = 1'b0;
                    n.st = AOC_IDLE;
                end
            end
            default: begin
                n.st = AOC_IDLE;
            end
        endcase

        if (r.ctrl[CTL_RST]) begin
            n.st = AOC_IDLE;
            n.cs_n = 1'b1;
            n.rd_n = 1'b1;
            n.cnv_n = 1'b1;
            n.sclk = 1'b0;
            n.sclk_oe = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= HOST_RST;
        end else begin
            r <= n;
        end
    end

    assign wb_dat_o = r.rdat;
    assign wb_ack_o = r.ack;
    assign pin.cs_n = r.cs_n;
    assign pin.rd_n = r.rd_n;
    assign pin.convert_start_n = r.cnv_n;
    assign pin.adc_reset = r.ctrl[CTL_RST];
    assign pin.power_down_request = r.ctrl[CTL_PD];
    assign pin.serial_parallel_select = r.ctrl[CTL_SER];
    assign pin.clock_source_select = r.ctrl[CTL_EXT];
    assign pin.frame_sync_invert = r.ctrl[CTL_INV];
    assign pin.internal_ref_disable = r.ctrl[CTL_REFD];
    assign pin.ref_buffer_disable = r.ctrl[CTL_BUFD];
    assign pin.host_sclk = r.sclk;
    assign pin.host_sclk_oe = r.sclk_oe;
endmodule
`default_nettype wire

/* verif/aoc_asserts.sv */
// Pin-level checks on the link between the converter and its host controller.
// Assumes one 10 MHz clock and sits beside the link interface in the bench.
`timescale 1ns/1ps
`default_nettype none
module aoc_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic adc_reset,
    input wire logic power_down_request,
    input wire logic serial_parallel_select,
    input wire logic clock_source_select,
    input wire logic frame_sync_invert,
    input wire logic [15:0] data_oe,
    input wire logic busy,
    input wire logic [15:0] pins
);
    logic [2:0] cfg;
    logic [2:0] cfg_q;
    logic [3:0] age;
    logic ser;
    logic par;
    logic act;
    assign cfg = {serial_parallel_select, clock_source_select, frame_sync_invert};
    // Mode pins pass synchronisers, so mode checks wait until the settings have settled.
    assign ser = serial_parallel_select && age == 4'hf;
    assign par = !serial_parallel_select && age == 4'hf;
    assign act = pins[10] ^ frame_sync_invert;
    always_ff @(posedge clk_i) begin
        cfg_q <= cfg;
        if (rst_i || cfg != cfg_q) begin
            age <= 4'h0;
        end else if (age != 4'hf) begin
            age <= age + 4'h1;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence conv_start;
        $rose(busy);
    endsequence
    sequence sync_start;
        ser && data_oe[10] && $stable(frame_sync_invert) && $rose(act);
    endsequence
    sequence err_pulse;
        pins[11] [*8] ##1 !pins[11];
    endsequence
    oe_gate_a: assert property ((cs_n || rd_n) [*8] |-> data_oe == 16'h0000)
        else $error("output drivers on without select and read");
    top_out_a: assert property (data_oe != 16'h0000 |-> data_oe[15:12] == 4'hf)
        else $error("upper data pins not driven");
    par_bus_a: assert property (par && data_oe != 16'h0000 |-> data_oe == 16'hffff)
        else $error("parallel read does not drive all pins");
    err_mode_a: assert property (ser && !clock_source_select |-> !pins[11])
        else $error("error flag raised in internal clock mode");
    err_len_a: assert property (ser && clock_source_select && $rose(pins[11]) |-> err_pulse)
        else $error("error flag pulse length wrong");
    clk_dir_a: assert property (ser && data_oe[8] |-> data_oe[9] == !clock_source_select)
        else $error("serial clock pin direction wrong");
    sync_hold_a: assert property (sync_start |-> act [*8])
        else $error("frame sync dropped early");
    busy_hold_a: assert property (conv_start |-> (busy || adc_reset) [*8])
        else $error("busy fell early");
    busy_end_a: assert property (conv_start |-> ##[9:20] !busy)
        else $error("busy never fell");
    rst_abort_a: assert property (adc_reset [*8] |-> !busy && data_oe == 16'h0000)
        else $error("reset pin did not abort");
    pd_block_a: assert property (power_down_request [*8] ##0 !busy |=> !busy)
        else $error("conversion started in power down");
endmodule
`default_nettype wire

/* verif/test_adc_conversion_and_output_control.sv */
// Self-checking bench: host controller and converter joined by the pin link.
// Assumes the design's default counts: acquisition 3 cycles, conversion 10 cycles.
`timescale 1ns/1ps
`default_nettype none
module test_adc_conversion_and_output_control;
    import aoc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] smp = 16'h0000;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] dat_o;
    logic ack;
    logic ref_on;
    logic buf_on;
    logic low_pw;
    logic [31:0] rq;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    aoc_if link ();
    aoc_device aoc_device_inst (.clk_i(clk_i), .rst_i(rst_i), .sample_i(smp),
        .ref_on_o(ref_on), .ref_buf_on_o(buf_on), .low_power_o(low_pw), .pin(link));
    aoc_host aoc_host_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .pin(link));
    aoc_asserts aoc_asserts_inst (.clk_i(clk_i), .rst_i(rst_i), .cs_n(link.cs_n),
        .rd_n(link.rd_n), .adc_reset(link.adc_reset),
        .power_down_request(link.power_down_request),
        .serial_parallel_select(link.serial_parallel_select),
        .clock_source_select(link.clock_source_select),
        .frame_sync_invert(link.frame_sync_invert), .data_oe(link.data_oe),
        .busy(link.busy), .pins(link.pins));
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("Counts: compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // The slave answers one cycle after taking the request; the wait is still bounded.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rq = dat_o;
        chk(n, 2, "ack latency");
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic go(input logic [7:0] c);
        wb(1'b1, REG_CTRL, {24'h0, c});
        repeat (12) @(posedge clk_i);
        wb(1'b1, REG_CTRL, {24'h0, c | 8'h01});
    endtask
    task automatic finish_read(input logic [15:0] exp);
        int n;
        n = 0;
        do begin
            wb(1'b0, REG_STAT, 32'h0);
            n++;
        end while (rq[ST_DONE] !== 1'b1 && n < 400);
        wb(1'b0, REG_DATA, 32'h0);
        chk(rq, {16'h0000, exp}, "result word");
    endtask
    // Collects sixteen serial bits at the edge on which the host samples them.
    task automatic watch(input logic inv, input logic rise, input logic [15:0] exp);
        logic [15:0] got;
        logic prev;
        int n;
        got = 16'h0000;
        for (n = 0; n < 3000 && !(link.data_oe[10] === 1'b1 && link.pins[10] === !inv); n++)
            @(posedge clk_i);
        chk({31'h0, link.data_oe[9]}, {31'h0, rise}, "clock pin direction");
        repeat (16) begin
            do begin
                prev = link.pins[9];
                @(posedge clk_i);
                n++;
            end while (!(link.pins[9] === rise && prev === !rise) && n < 6000);
            chk({31'h0, link.pins[10]}, {31'h0, !inv}, "frame sync level");
            got = {got[14:0], link.pins[8]};
        end
        chk({16'h0, got}, {16'h0, exp}, "serial word");
    endtask
    task automatic t_parallel();
        int b;
        int p;
        smp <= 16'ha5c3;
        go(8'h00);
        fork
            begin
                for (b = 0; b < 100 && link.busy !== 1'b1; b++) @(posedge clk_i);
                for (b = 0; b < 100 && link.busy === 1'b1; b++) @(posedge clk_i);
                chk(b, CONV_CYCLES, "busy length");
            end
            begin
                for (p = 0; p < 200 && link.data_oe !== 16'hffff; p++) @(posedge clk_i);
                @(posedge clk_i);
                chk({16'h0, link.pins}, 32'h0000_a5c3, "parallel pins");
            end
            finish_read(16'ha5c3);
        join
        $display("test parallel done");
    endtask
    task automatic t_serial();
        logic [15:0] v;
        logic [7:0] c;
        for (int i = 0; i < 3; i++) begin
            v = (i == 0) ? 16'hc35a : (i == 1) ? 16'h3ca5 : 16'h96e1;
            c = 8'h02 | ((i == 1) ? 8'h08 : 8'h00) | ((i == 2) ? 8'h04 : 8'h00);
            smp <= v;
            go(c);
            fork
                watch(c[CTL_INV], i != 2, v);
                finish_read(v);
            join
            wb(1'b0, REG_STAT, 32'h0);
            chk({31'h0, rq[ST_ERR]}, 32'h0, "no error on complete read");
            $display("test serial %0d done", i);
        end
    endtask
    task automatic t_ref();
        for (int k = 0; k < 4; k++) begin
            wb(1'b1, REG_CTRL, {24'h0, k[1:0], 6'h00});
            repeat (10) @(posedge clk_i);
            chk({30'h0, buf_on, ref_on}, {30'h0, ~k[1], ~k[0]}, "reference enables");
        end
        $display("test reference done");
    endtask
    task automatic t_abort();
        int n;
        go(8'h00);
        for (n = 0; n < 100 && link.busy !== 1'b1; n++) @(posedge clk_i);
        fork
            for (n = 0; n < 100 && link.busy === 1'b1; n++) @(posedge clk_i);
            wb(1'b1, REG_CTRL, 32'h0000_0020);
        join
        chk({31'h0, n < 10}, 32'h1, "conversion aborted early");
        repeat (20) @(posedge clk_i);
        chk({31'h0, link.busy}, 32'h0, "busy held off in reset");
        wb(1'b1, REG_CTRL, 32'h0);
        wb(1'b0, REG_STAT, 32'h0);
        for (n = 0; n < 200 && rq[ST_ENG] !== 1'b0; n++) wb(1'b0, REG_STAT, 32'h0);
        wb(1'b0, REG_DATA, 32'h0);
        $display("test abort done");
    endtask
    task automatic t_power();
        int n;
        smp <= 16'h7e18;
        go(8'h00);
        for (n = 0; n < 100 && link.busy !== 1'b1; n++) @(posedge clk_i);
        wb(1'b1, REG_CTRL, 32'h0000_0010);
        finish_read(16'h7e18);
        repeat (8) @(posedge clk_i);
        chk({31'h0, low_pw}, 32'h1, "low power");
        wb(1'b1, REG_CTRL, 32'h0000_0011);
        repeat (40) @(posedge clk_i);
        wb(1'b0, REG_STAT, 32'h0);
        chk({30'h0, rq[ST_DONE], link.busy}, 32'h0, "start refused");
        $display("test power down done");
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        wb(1'b0, REG_CTRL, 32'h0);
        chk(rq, 32'h0, "control reset value");
        wb(1'b0, 8'h0c, 32'h0);
        chk(rq, 32'h0, "unmapped read");
        t_parallel();
        t_serial();
        t_ref();
        t_abort();
        t_power();
        end_sim();
    end
endmodule
`default_nettype wire
